// ---- ssc_pkg.sv ----
// Purpose: shared constants, types and delay table of the slot sequencer
// Assumes: core clock of 40 MHz
// Notes: times kept in their own unit, cycle counts derived from them
// Operation
// - monitor code 1..12 picks slot 1..12, 0 none
// - enable code 1..12 picks slot 0..11, 0 none
// - fault timeout codes 37.5, 75, 150, 300 ms
// - bits 7..4 enable sense input pulldowns
// - retry code picks 20us up to 2.4s
// - recovery bit: 0 autoretry, 1 latch off
// - slew code picks 800 down to 100 V/s
// - deglitch code picks 2, 4, 8, 16 conversions
// - slot delays packed as consecutive 3-bit codes
// - slot 2 delay straddles first two registers
// - slot 5 delay straddles second and third
// - slot 10 delay straddles fourth and fifth
// - reverse bit: 0 simultaneous, 1 reverse power-down
// - delay code 0..7 picks 20us to 2.4s
// - slots ascend, outputs turn on after delay
// - slot monitors must pass within power-up timeout
// - reverse power-down steps from slot 11 down
package ssc_pkg;
	localparam int NCH = 12;
	localparam int CFG_N = 22;
	localparam int TK_W = 11;
	localparam int CYC_W = 17;
	localparam logic [7:0] CFG_BASE = 8'h4E;
	localparam logic [7:0] OFS_FLT_TMO = 8'h4E;
	localparam logic [7:0] OFS_RETRY = 8'h4F;
	localparam logic [7:0] OFS_DLY_A = 8'h50;
	localparam logic [7:0] OFS_DLY_B = 8'h51;
	localparam logic [7:0] OFS_DLY_C = 8'h52;
	localparam logic [7:0] OFS_DLY_D = 8'h53;
	localparam logic [7:0] OFS_DLY_E = 8'h54;
	localparam logic [7:0] OFS_MON = 8'h56;
	localparam logic [7:0] OFS_MON_END = 8'h5B;
	localparam logic [7:0] OFS_EN = 8'h5E;
	localparam logic [7:0] OFS_EN_END = 8'h63;
	localparam int IDX_FLT = int'(OFS_FLT_TMO - CFG_BASE);
	localparam int IDX_RETRY = int'(OFS_RETRY - CFG_BASE);
	localparam int IDX_DLY_A = int'(OFS_DLY_A - CFG_BASE);
	localparam int IDX_DLY_B = int'(OFS_DLY_B - CFG_BASE);
	localparam int IDX_DLY_C = int'(OFS_DLY_C - CFG_BASE);
	localparam int IDX_DLY_D = int'(OFS_DLY_D - CFG_BASE);
	localparam int IDX_DLY_E = int'(OFS_DLY_E - CFG_BASE);
	localparam int IDX_MON = int'(OFS_MON - CFG_BASE);
	localparam int IDX_EN = int'(OFS_EN - CFG_BASE);
	localparam int PU_TMO_LSB = 0;
	localparam int PD_TMO_LSB = 2;
	localparam int PULLDN_LSB = 4;
	localparam int RETRY_LSB = 0;
	localparam int RECOV_BIT = 3;
	localparam int SLEW_LSB = 4;
	localparam int DEGL_LSB = 6;
	localparam int REV_BIT = 4;
	localparam logic [7:0] REV_WMASK = 8'h1F;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [3:0] CODE_MAX = 4'hC;
	localparam logic [3:0] SLOT_LAST = 4'hB;
	localparam logic [3:0] SLOT_MON_LAST = 4'hC;
	localparam logic [2:0] RETRY_GAP = 3'h6;
	localparam logic [2:0] RETRY_NEAR = 3'h5;
	localparam logic [2:0] TMO_BASE = 3'h2;
	localparam logic [4:0] DEGL_BASE = 5'h02;
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_SHORT_NS = 20000;
	localparam int SHORT_CYC = T_SHORT_NS / CLK_PERIOD_NS;
	localparam int T_TICK_NS = 1250000;
	localparam int TICK_CYC_DFLT = T_TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_US = T_TICK_NS / 1000;
	localparam int T_18750_US = 18750;
	localparam int T_37500_US = 37500;
	localparam int T_75_MS_US = 75000;
	localparam int T_150_MS_US = 150000;
	localparam int T_300_MS_US = 300000;
	localparam int T_600_MS_US = 600000;
	localparam int T_2400_MS_US = 2400000;

	typedef enum logic [2:0] {
		S_OFF = 3'h0,
		S_DLY = 3'h1,
		S_CHK = 3'h3,
		S_ON = 3'h2,
		S_DOWN = 3'h6,
		S_FAULT = 3'h7,
		S_LATCH = 3'h5
	} ssc_state_e;

	// code 0 is the short 20us delay, timed in plain cycles
	function automatic logic [TK_W-1:0] dly_ticks(input logic [2:0] code);
		unique case (code)
			3'h0: dly_ticks = '0;
			3'h1: dly_ticks = TK_W'(T_18750_US / TICK_US);
			3'h2: dly_ticks = TK_W'(T_37500_US / TICK_US);
			3'h3: dly_ticks = TK_W'(T_75_MS_US / TICK_US);
			3'h4: dly_ticks = TK_W'(T_150_MS_US / TICK_US);
			3'h5: dly_ticks = TK_W'(T_300_MS_US / TICK_US);
			3'h6: dly_ticks = TK_W'(T_600_MS_US / TICK_US);
			3'h7: dly_ticks = TK_W'(T_2400_MS_US / TICK_US);
		endcase
	endfunction
endpackage

// ---- ssc_tmr_if.sv ----
// Purpose: start and expiry handshake between sequencer and its timer
// Assumes: one clock for both ends
// Notes: ticks unused when the short delay is selected
`timescale 1ns/100ps
`default_nettype none
interface ssc_tmr_if;
	logic start;
	logic short_sel;
	logic [ssc_pkg::TK_W-1:0] ticks;
	logic expired;
	modport seq (output start, output short_sel, output ticks, input expired);
	modport tmr (input start, input short_sel, input ticks, output expired);
endinterface
`default_nettype wire

// ---- ssc_timer.sv ----
// Purpose: one-shot delay timer, short cycle count or 1.25 ms ticks
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the count and clears expiry
`timescale 1ns/100ps
`default_nettype none
module ssc_timer import ssc_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYC_DFLT
) (
	input wire logic core_clk,
	input wire logic srst,
	ssc_tmr_if.tmr t
);
	typedef struct packed {
		logic run;
		logic exp;
		logic [CYC_W-1:0] cyc;
		logic [TK_W-1:0] rem;
	} ssc_tmr_s;

	ssc_tmr_s q_reg, q_next;

	always_comb begin
		q_next = q_reg;
		if (t.start) begin
			q_next.run = 1'b1;
			q_next.exp = 1'b0;
			q_next.cyc = t.short_sel ? CYC_W'(SHORT_CYC - 1) : CYC_W'(TICK_CYC - 1);
			q_next.rem = t.short_sel ? '0 : t.ticks - 11'h001;
		end else if (q_reg.run) begin
			if (q_reg.cyc != '0) begin
				q_next.cyc = q_reg.cyc - 17'h00001;
			end else if (q_reg.rem != '0) begin
				q_next.rem = q_reg.rem - 11'h001;
				q_next.cyc = CYC_W'(TICK_CYC - 1);
			end else begin
				q_next.run = 1'b0;
				q_next.exp = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign t.expired = q_reg.exp;
endmodule
`default_nettype wire

// ---- ssc_sequencer.sv ----
// Purpose: slot power sequencer with its configuration registers
// Assumes: enable request and monitor levels are asynchronous pins
// Notes: writes are refused while a sequence is running
`timescale 1ns/100ps
`default_nettype none
module ssc_sequencer import ssc_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYC_DFLT
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	output logic cfg_busy,
	input wire logic seq_enable,
	input wire logic [NCH-1:0] supply_monitor_input,
	output logic [NCH-1:0] enable_output,
	output logic [3:0] tracking_sense_pulldown_en,
	output logic [1:0] ramp_slew_code,
	output logic [4:0] fault_deglitch_conv,
	output logic [1:0] pd_timeout_code,
	output logic seq_fault,
	output logic power_good
);
	typedef struct packed {
		logic [1:0] en_sy;
		logic [NCH-1:0] mon_s1;
		logic [NCH-1:0] mon_s2;
		ssc_state_e st;
		logic [3:0] slot;
		logic fresh;
		logic [NCH-1:0] en_out;
		logic fault;
		logic pg;
		logic [7:0] rd;
		logic [CFG_N-1:0][7:0] cfg;
	} ssc_seq_s;

	ssc_seq_s r_reg, r_next;
	ssc_tmr_if tmr();
	logic [38:0] dly_vec;
	logic [2:0] dly_code;
	logic [2:0] t_code;
	logic [2:0] retry_code;
	logic [NCH-1:0] mon_in_slot;
	logic [NCH-1:0] en_in_slot;
	logic [NCH-1:0] en_unused;
	logic en_ok;
	logic mons_ok;
	logic rev_mode;
	logic latch_mode;
	logic busy;
	logic mapped;
	logic pd_req;
	logic [7:0] cfg_ofs;
	logic [4:0] cfg_idx;

	ssc_timer #(.TICK_CYC(TICK_CYC)) u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.t(tmr.tmr)
	);

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	assign dly_vec = {3'h0, r_reg.cfg[IDX_DLY_E][3:0], r_reg.cfg[IDX_DLY_D], r_reg.cfg[IDX_DLY_C],
		r_reg.cfg[IDX_DLY_B], r_reg.cfg[IDX_DLY_A]};
	assign dly_code = dly_vec[3 * r_reg.slot +: 3];
	assign retry_code = r_reg.cfg[IDX_RETRY][RETRY_LSB +: 3];
	assign rev_mode = r_reg.cfg[IDX_DLY_E][REV_BIT];
	assign latch_mode = r_reg.cfg[IDX_RETRY][RECOV_BIT];
	assign en_ok = r_reg.en_sy[1];
	assign busy = r_reg.st inside {S_DLY, S_CHK, S_DOWN};
	assign cfg_ofs = cfg_addr - CFG_BASE;
	assign cfg_idx = cfg_ofs[4:0];
	assign mapped = cfg_addr inside {[OFS_FLT_TMO:OFS_DLY_E], [OFS_MON:OFS_MON_END], [OFS_EN:OFS_EN_END]};

	// codes above 12 never match a slot, so they stay unassigned
	always_comb begin
		mon_in_slot = '0;
		en_in_slot = '0;
		en_unused = '0;
		for (int i = 0; i < NCH; i++) begin
			if (r_reg.cfg[IDX_MON + i / 2][4 * (i % 2) +: 4] == r_reg.slot && r_reg.slot != 4'h0) begin
				mon_in_slot[i] = 1'b1;
			end
			if (r_reg.cfg[IDX_EN + i / 2][4 * (i % 2) +: 4] == r_reg.slot + 4'h1 && r_reg.slot <= SLOT_LAST) begin
				en_in_slot[i] = 1'b1;
			end
			en_unused[i] = r_reg.cfg[IDX_EN + i / 2][4 * (i % 2) +: 4] > CODE_MAX;
		end
	end

	assign mons_ok = &(r_reg.mon_s2 | ~mon_in_slot);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		tmr.start = 1'b0;
		t_code = dly_code;
		pd_req = 1'b0;
		r_next.en_sy = {r_reg.en_sy[0], seq_enable};
		r_next.mon_s1 = supply_monitor_input;
		r_next.mon_s2 = r_reg.mon_s1;
		r_next.rd = 8'h00;
		if (cfg_rd_en && mapped) begin
			r_next.rd = r_reg.cfg[cfg_idx];
		end
		// a write mid-sequence would change timing under our feet
		if (cfg_wr_en && mapped && !busy) begin
			r_next.cfg[cfg_idx] = cfg_wr_data & ((cfg_addr == OFS_DLY_E) ? REV_WMASK : 8'hFF);
		end
		unique case (r_reg.st)
			S_OFF: begin
				r_next.slot = 4'h0;
				r_next.pg = 1'b0;
				if (en_ok) begin
					r_next.st = S_DLY;
					r_next.fault = 1'b0;
					// slot may still hold the faulted slot after a retry
					t_code = dly_vec[2:0];
					tmr.start = 1'b1;
				end
			end
			S_DLY: begin
				if (!en_ok) begin
					pd_req = 1'b1;
				end else if (tmr.expired) begin
					r_next.en_out = r_reg.en_out | en_in_slot;
					r_next.slot = r_reg.slot + 4'h1;
					r_next.st = S_CHK;
					tmr.start = 1'b1;
					t_code = TMO_BASE + {1'b0, r_reg.cfg[IDX_FLT][PU_TMO_LSB +: 2]};
				end
			end
			S_CHK: begin
				if (!en_ok) begin
					pd_req = 1'b1;
				end else if (mons_ok) begin
					if (r_reg.slot == SLOT_MON_LAST) begin
						r_next.st = S_ON;
						r_next.pg = 1'b1;
					end else begin
						r_next.st = S_DLY;
						tmr.start = 1'b1;
					end
				end else if (tmr.expired) begin
					r_next.st = S_FAULT;
					r_next.en_out = '0;
					r_next.fault = 1'b1;
					tmr.start = 1'b1;
					t_code = (retry_code == RETRY_GAP) ? RETRY_NEAR : retry_code;
				end
			end
			S_ON: begin
				if (!en_ok) begin
					pd_req = 1'b1;
				end
			end
			S_DOWN: begin
				if (r_reg.fresh) begin
					r_next.en_out = r_reg.en_out & ~en_in_slot;
					r_next.fresh = 1'b0;
					tmr.start = 1'b1;
				end else if (tmr.expired) begin
					if (r_reg.slot == 4'h0) begin
						r_next.st = S_OFF;
					end else begin
						r_next.slot = r_reg.slot - 4'h1;
						r_next.fresh = 1'b1;
					end
				end
			end
			S_FAULT: begin
				r_next.en_out = '0;
				if (latch_mode) begin
					r_next.st = S_LATCH;
				end else if (tmr.expired) begin
					r_next.st = S_OFF;
				end
			end
			S_LATCH: begin
				r_next.en_out = '0;
				if (!en_ok) begin
					r_next.st = S_OFF;
				end
			end
			default: begin
				r_next.st = S_OFF;
				r_next.en_out = '0;
			end
		endcase
		if (pd_req) begin
			r_next.pg = 1'b0;
			if (rev_mode) begin
				r_next.st = S_DOWN;
				r_next.slot = SLOT_LAST;
				r_next.fresh = 1'b1;
			end else begin
				r_next.st = S_OFF;
				r_next.slot = 4'h0;
				r_next.en_out = '0;
			end
		end
		tmr.short_sel = (t_code == 3'h0);
		tmr.ticks = dly_ticks(t_code);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r_reg <= '0;
			r_reg.st <= S_OFF;
			r_reg.cfg <= {CFG_N{CFG_RST}};
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cfg_rd_data = r_reg.rd;
	assign cfg_busy = busy;
	assign enable_output = r_reg.en_out;
	assign seq_fault = r_reg.fault;
	assign power_good = r_reg.pg;
	assign tracking_sense_pulldown_en = r_reg.cfg[IDX_FLT][PULLDN_LSB +: 4];
	assign pd_timeout_code = r_reg.cfg[IDX_FLT][PD_TMO_LSB +: 2];
	assign ramp_slew_code = r_reg.cfg[IDX_RETRY][SLEW_LSB +: 2];
	assign fault_deglitch_conv = DEGL_BASE << r_reg.cfg[IDX_RETRY][DEGL_LSB +: 2];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	AST_EN_RISE_DLY: assert property (
		|(enable_output & ~$past(enable_output)) |-> $past(r_reg.st) == S_DLY && $past(tmr.expired)
	) else $error("enable rose outside slot end");
	AST_EN_SLOT_MAP: assert property (
		r_reg.st == S_DLY && tmr.expired && en_ok |=> enable_output == ($past(enable_output) | $past(en_in_slot))
	) else $error("slot outputs not switched on");
	AST_EN_UNUSED: assert property (
		(enable_output & ~$past(enable_output) & en_unused) == '0
	) else $error("unassigned enable output switched on");
	AST_PU_TIMEOUT: assert property (
		r_reg.st == S_CHK && en_ok && !mons_ok && tmr.expired |=> r_reg.st == S_FAULT && enable_output == '0 && seq_fault
	) else $error("power-up timeout did not fault");
	AST_LATCH_OFF: assert property (
		r_reg.st == S_FAULT && latch_mode |=> r_reg.st == S_LATCH ##1 enable_output == '0
	) else $error("latch-off not taken");
	AST_SIM_DOWN: assert property (
		r_reg.st == S_ON && !en_ok && !rev_mode |=> enable_output == '0 && r_reg.st == S_OFF && !power_good
	) else $error("simultaneous power-down failed");
	AST_REV_DOWN: assert property (
		r_reg.st == S_ON && !en_ok && rev_mode |=> r_reg.st == S_DOWN && r_reg.slot == 4'hB
			##1 (enable_output & $past(en_in_slot)) == '0
	) else $error("reverse power-down did not start at slot 11");
	AST_CFG_LOCK: assert property (
		busy |=> $stable(r_reg.cfg)
	) else $error("configuration changed during a sequence");
	AST_PULLDN: assert property (
		cfg_wr_en && !busy && cfg_addr == OFS_FLT_TMO |=> tracking_sense_pulldown_en == $past(cfg_wr_data[7:4])
	) else $error("pulldown enables not taken from write");
	AST_DEGLITCH: assert property (
		cfg_wr_en && !busy && cfg_addr == OFS_RETRY |=> fault_deglitch_conv == (5'h02 << $past(cfg_wr_data[7:6]))
	) else $error("deglitch count wrong");
	AST_SLOT0_DLY: assert property (
		r_reg.st == S_OFF && en_ok |-> tmr.start && tmr.short_sel == (r_reg.cfg[IDX_DLY_A][2:0] == 3'h0)
	) else $error("slot 0 delay not started from its own code");
	AST_SLOT2_DLY: assert property (
		r_reg.slot == 4'h2 |-> dly_code == {r_reg.cfg[IDX_DLY_B][0], r_reg.cfg[IDX_DLY_A][7:6]}
	) else $error("slot 2 delay code wrongly assembled");
	AST_SLOT5_DLY: assert property (
		r_reg.slot == 4'h5 |-> dly_code == {r_reg.cfg[IDX_DLY_C][1:0], r_reg.cfg[IDX_DLY_B][7]}
	) else $error("slot 5 delay code wrongly assembled");
	AST_SLOT10_DLY: assert property (
		r_reg.slot == 4'hA |-> dly_code == {r_reg.cfg[IDX_DLY_E][0], r_reg.cfg[IDX_DLY_D][7:6]}
	) else $error("slot 10 delay code wrongly assembled");
	AST_SLOT11_DLY: assert property (
		r_reg.slot == 4'hB |-> dly_code == r_reg.cfg[IDX_DLY_E][3:1]
	) else $error("slot 11 delay code wrongly assembled");
	AST_PU_TMO_TICKS: assert property (
		r_reg.st == S_DLY && tmr.expired && en_ok |-> tmr.start && !tmr.short_sel
			&& tmr.ticks == (TK_W'(T_37500_US / TICK_US) << r_reg.cfg[IDX_FLT][PU_TMO_LSB +: 2])
	) else $error("power-up timeout length wrong");
	AST_RETRY_NEAR: assert property (
		r_reg.st == S_CHK && en_ok && !mons_ok && tmr.expired && retry_code == RETRY_GAP
			|-> tmr.start && tmr.ticks == TK_W'(T_300_MS_US / TICK_US)
	) else $error("unlisted retry code not mapped to nearest");
	AST_FAULT_OUTS: assert property (
		r_reg.st inside {S_FAULT, S_LATCH} |-> enable_output == '0
	) else $error("enable output high after fault");
	AST_RD_IDLE: assert property (
		!$past(cfg_rd_en) |-> cfg_rd_data == 8'h00
	) else $error("read data not idle");
	AST_PG_ON: assert property (
		power_good |-> r_reg.st == S_ON
	) else $error("power good outside on state");
endmodule
`default_nettype wire

// ---- ssc_supply_model.sv ----
// Purpose: external supplies, each rail follows its enable after a lag
// Assumes: one supply per channel, monitor i watches supply i
// Notes: fail_mask holds a rail low to provoke a power-up fault
`timescale 1ns/100ps
`default_nettype none
module ssc_supply_model import ssc_pkg::*; #(
	parameter int LAG = 20
) (
	input wire logic core_clk,
	input wire logic [NCH-1:0] enable_output,
	input wire logic [NCH-1:0] fail_mask,
	output logic [NCH-1:0] supply_monitor_input
);
	logic [NCH-1:0] ramp [LAG] = '{default: '0};
	always @(posedge core_clk) begin
		ramp[0] <= enable_output;
		for (int i = 1; i < LAG; i++) begin
			ramp[i] <= ramp[i - 1];
		end
	end
	// rail collapses at once without its enable, but rises only after the lag
	assign supply_monitor_input = ramp[LAG - 1] & enable_output & ~fail_mask;
endmodule
`default_nettype wire

// ---- ssc_sequencer_bench.sv ----
// Purpose: self-checking bench of the slot sequencer
// Assumes: TICK_CYC of 4, so delay code 1 lasts 60 cycles
// Notes: reads are noted in a queue and checked by a watcher
`timescale 1ns/100ps
`default_nettype none
module ssc_sequencer_bench import ssc_pkg::*;;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic cfg_wr_en = 1'b0;
	logic cfg_rd_en = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [7:0] cfg_wr_data = 8'h00;
	logic seq_enable = 1'b0;
	logic [NCH-1:0] fail_mask = '0;
	logic [7:0] cfg_rd_data;
	logic cfg_busy, seq_fault, power_good;
	logic [NCH-1:0] supply_monitor_input, enable_output;
	logic [3:0] pulldn;
	logic [1:0] slew, pd_code;
	logic [4:0] degl;
	logic [7:0] rd_q[$];
	logic rd_seen = 1'b0;
	int err_total = 0;
	int tests_run = 0;
	int seed = 32'h5C4873D2;
	logic [7:0] d;
	logic [11:0] prev;
	int k, g;

	ssc_sequencer #(.TICK_CYC(4)) dut_u (.core_clk(core_clk), .srst(srst), .cfg_wr_en(cfg_wr_en),
		.cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
		.cfg_busy(cfg_busy), .seq_enable(seq_enable), .supply_monitor_input(supply_monitor_input),
		.enable_output(enable_output), .tracking_sense_pulldown_en(pulldn), .ramp_slew_code(slew),
		.fault_deglitch_conv(degl), .pd_timeout_code(pd_code), .seq_fault(seq_fault), .power_good(power_good));
	ssc_supply_model supply_u (.core_clk(core_clk), .enable_output(enable_output), .fail_mask(fail_mask),
		.supply_monitor_input(supply_monitor_input));

	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: level %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		cfg_wr_en <= 1'b1;
		cfg_addr <= a;
		cfg_wr_data <= v;
		@(posedge core_clk);
		cfg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		@(posedge core_clk);
		cfg_rd_en <= 1'b1;
		cfg_addr <= a;
		@(posedge core_clk);
		cfg_rd_en <= 1'b0;
	endtask
	// read data stands one cycle only, so it is taken right then
	always @(posedge core_clk) begin
		if (rd_seen) begin
			chk_rd(cfg_rd_data, rd_q.pop_front());
		end
		rd_seen <= cfg_rd_en;
	end

	// ----------------------------------------
	// sequencing tasks
	// ----------------------------------------
	task automatic power_up();
		prev = '0;
		k = 0;
		g = 0;
		@(posedge core_clk);
		seq_enable <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk({11'h0, cfg_busy}, 12'h001);
		wr(OFS_FLT_TMO, 8'hFF);
		for (int n = 0; n < 3000 && power_good !== 1'b1; n++) begin
			@(negedge core_clk);
			g++;
			if (enable_output !== prev) begin
				chk(enable_output, prev | (12'h001 << k));
				// code-1 slot of 60 cycles, rail lag of 20, sync and state steps
				if (k > 0) chk({11'h0, g >= 80 && g <= 88}, 12'h001);
				prev = enable_output;
				k++;
				g = 0;
			end
		end
		chk(12'(k), 12'h00C);
		chk({11'h0, power_good}, 12'h001);
		rd(OFS_FLT_TMO, 8'h8F);
	endtask
	task automatic power_down(input logic rev);
		@(posedge core_clk);
		seq_enable <= 1'b0;
		k = 11;
		for (int n = 0; n < 3000 && enable_output !== 12'h000; n++) begin
			@(negedge core_clk);
			if (enable_output !== prev) begin
				chk(enable_output, rev ? prev & ~(12'h001 << k) : 12'h000);
				prev = enable_output;
				k--;
			end
		end
		chk(enable_output, 12'h000);
		chk({11'h0, power_good}, 12'h000);
		repeat (100) @(posedge core_clk);
	endtask
	task automatic fault_run(input logic [7:0] rcv, input logic [11:0] exp_pg, input logic [11:0] exp_en);
		wr(OFS_RETRY, rcv);
		fail_mask <= 12'h008;
		@(posedge core_clk);
		seq_enable <= 1'b1;
		for (int n = 0; n < 3000 && seq_fault !== 1'b1; n++) @(negedge core_clk);
		chk({11'h0, seq_fault}, 12'h001);
		@(negedge core_clk);
		chk(enable_output, 12'h000);
		@(posedge core_clk);
		fail_mask <= '0;
		repeat (3000) @(posedge core_clk);
		chk({11'h0, power_good}, exp_pg);
		chk(enable_output, exp_en);
		@(posedge core_clk);
		seq_enable <= 1'b0;
		repeat (100) @(posedge core_clk);
	endtask
	task automatic results();
		$display("counts: %0d compared, %0d mismatched", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		for (int a = 8'h4E; a <= 8'h54; a++) rd(8'(a), 8'h00);
		@(negedge core_clk);
		chk({7'h0, degl}, 12'h002);
		$display("test reset done");
		for (int a = 8'h4E; a <= 8'h55; a++) begin
			d = 8'($random(seed));
			wr(8'(a), d);
			rd(8'(a), a == 8'h55 ? 8'h00 : a == 8'h54 ? d & REV_WMASK : d);
		end
		for (int j = 0; j < 4; j++) begin
			wr(OFS_FLT_TMO, {4'(1 << j), 2'(j), 2'(j)});
			wr(OFS_RETRY, {2'(j), 2'(j), 4'h0});
			@(negedge core_clk);
			chk({8'h0, pulldn}, 12'(1 << j));
			chk({10'h0, pd_code}, 12'(j));
			chk({10'h0, slew}, 12'(j));
			chk({7'h0, degl}, 12'(2 << j));
		end
		$display("test registers done");
		// supply i enabled in slot i and watched from slot i+1
		for (int j = 0; j < 6; j++) begin
			wr(OFS_MON + 8'(j), {4'(2 * j + 2), 4'(2 * j + 1)});
			wr(OFS_EN + 8'(j), {4'(2 * j + 2), 4'(2 * j + 1)});
		end
		// every slot delay code 1, straddling fields included
		wr(OFS_DLY_A, 8'h49);
		wr(OFS_DLY_B, 8'h92);
		wr(OFS_DLY_C, 8'h24);
		wr(OFS_DLY_D, 8'h49);
		wr(OFS_DLY_E, 8'h12);
		power_up();
		power_down(1'b1);
		$display("test reverse sequence done");
		wr(OFS_DLY_E, 8'h02);
		power_up();
		power_down(1'b0);
		$display("test simultaneous sequence done");
		fault_run(8'h00, 12'h001, 12'hFFF);
		fault_run(8'h08, 12'h000, 12'h000);
		wr(OFS_MON, 8'h2D);
		wr(OFS_EN, 8'h2D);
		fault_run(8'h06, 12'h001, 12'hFFE);
		$display("test fault recovery done");
		results();
	end

	// hang guard, well beyond the roughly 16k cycles of the run
	initial begin
		repeat (40000) @(posedge core_clk);
		err_total++;
		results();
	end
endmodule
`default_nettype wire
